// ---- feq_pkg.sv ----
// constants shared by the equalizer coefficient bank
package feq_pkg;

	// ------------------------------------------------------------
	// bus and word widths
	// ------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 12;
	localparam int WORD_W = 16;
	localparam int COEF_W = 12;
	localparam int NUM_COEF = 5;
	localparam int SEL_W = 3;

	// ------------------------------------------------------------
	// filter shape
	// ------------------------------------------------------------
	localparam int NUM_TAPS = 9;
	localparam int CENTER_TAP = 5;
	localparam int CENTER_W = 18;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_A_TAP8 = 12'h427;
	localparam logic [IDX_W-1:0] IDX_A_TAP9 = 12'h429;
	localparam logic [IDX_W-1:0] IDX_B_TAP1 = 12'h448;
	localparam logic [IDX_W-1:0] IDX_B_TAP2 = 12'h44a;
	localparam logic [IDX_W-1:0] IDX_B_TAP3 = 12'h44c;
	localparam logic [IDX_W-1:0] IDX_MODE = 12'h460;

	// ------------------------------------------------------------
	// storage slots
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SLOT_A_TAP8 = 3'h0;
	localparam logic [SEL_W-1:0] SLOT_A_TAP9 = 3'h1;
	localparam logic [SEL_W-1:0] SLOT_B_TAP1 = 3'h2;
	localparam logic [SEL_W-1:0] SLOT_B_TAP2 = 3'h3;
	localparam logic [SEL_W-1:0] SLOT_B_TAP3 = 3'h4;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int SIGN_BIT = 11;
	localparam int MODE_SINGLE_BIT = 0;
	localparam logic [WORD_W-1:0] COEF_RESET = 16'h0000;
	localparam logic MODE_RESET = 1'b0;
	localparam logic [WORD_W-1:0] READ_MASK = 16'hf7ff;

endpackage

// ---- feq_coef_if.sv ----
// carrier between the bus front end and the coefficient store
`timescale 1ns/1ps
interface feq_coef_if;
	logic we;
	logic [feq_pkg::SEL_W-1:0] wsel;
	logic [feq_pkg::WORD_W-1:0] wdata;
	logic rd_en;
	logic [feq_pkg::SEL_W-1:0] rsel;
	logic [feq_pkg::WORD_W-1:0] rdata;
	logic [feq_pkg::NUM_COEF-1:0][feq_pkg::WORD_W-1:0] word;

	modport ctrl (output we, output wsel, output wdata, output rd_en, output rsel,
		input rdata, input word);
	modport store (input we, input wsel, input wdata, input rd_en, input rsel,
		output rdata, output word);
endinterface

// ---- feq_coef_store.sv ----
// storage of the coefficient words with registered read port
`timescale 1ns/1ps
module feq_coef_store (
	input wire logic pclk,
	input wire logic presetn,
	feq_coef_if.store bus
);
	logic [feq_pkg::NUM_COEF-1:0][feq_pkg::WORD_W-1:0] word_q;
	logic [feq_pkg::NUM_COEF-1:0][feq_pkg::WORD_W-1:0] word_d;
	logic [feq_pkg::WORD_W-1:0] rdata_q;
	logic [feq_pkg::WORD_W-1:0] rdata_d;

	// ------------------------------------------------------------
	// one word per slot
	// ------------------------------------------------------------
	for (genvar g = 0; g < feq_pkg::NUM_COEF; g++) begin : g_slot
		always_comb begin
			word_d[g] = word_q[g];
			if (bus.we && bus.wsel == feq_pkg::SEL_W'(g)) begin
				word_d[g] = bus.wdata;
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				word_q[g] <= feq_pkg::COEF_RESET;
			end else begin
				word_q[g] <= word_d[g];
			end
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = rdata_q;
		if (bus.rd_en) begin
			if (int'(bus.rsel) < feq_pkg::NUM_COEF) begin
				rdata_d = word_q[bus.rsel];
			end else begin
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign bus.rdata = rdata_q;
	assign bus.word = word_q;

endmodule // feq_coef_store

// ---- feq_coef_bank.sv ----
// apb register bank for the equalizer fir coefficients
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps

// Contract
// - each coefficient is 12-bit signed in bits 11:0; bits 15:12 reserved.
// - every coefficient register, reserved bits too, resets to zero.
// - 0x427 drives channel A tap eight in dual-channel mode.
// - in single-channel mode 0x427 drives tap eight of the combined filter.
// - 0x429 drives tap nine of channel A or of the single filter.
// - 0x448 drives channel B tap one in dual-channel mode.
// - 0x44A drives channel B tap two in dual-channel mode.
// - 0x44C drives channel B tap three in dual-channel mode.
// - readback always shows bit 11 as zero; software ignores it.
// - filter has nine taps; center tap five is 18-bit, others 12-bit.
module feq_coef_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [feq_pkg::ADDR_W-1:0] paddr,
	input wire logic [feq_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [feq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic single_channel,
	output logic signed [feq_pkg::COEF_W-1:0] chan_a_tap8_weight,
	output logic signed [feq_pkg::COEF_W-1:0] chan_a_tap9_weight,
	output logic signed [feq_pkg::COEF_W-1:0] chan_b_tap1_weight,
	output logic signed [feq_pkg::COEF_W-1:0] chan_b_tap2_weight,
	output logic signed [feq_pkg::COEF_W-1:0] chan_b_tap3_weight
);

	// ------------------------------------------------------------
	// store
	// ------------------------------------------------------------
	feq_coef_if coef ();

	feq_coef_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.bus(coef)
	);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic setup;
	logic access;
	logic hit_coef;
	logic hit_mode;
	logic [feq_pkg::SEL_W-1:0] sel;
	logic [feq_pkg::IDX_W-1:0] idx;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign idx = paddr[feq_pkg::IDX_W+1:2];

	always_comb begin
		hit_coef = 1'b0;
		hit_mode = 1'b0;
		sel = feq_pkg::SLOT_A_TAP8;
		if (paddr[1:0] == 2'h0 && paddr[feq_pkg::ADDR_W-1] == 1'b0
			&& paddr[feq_pkg::ADDR_W-2] == 1'b0) begin
			case (idx)
				feq_pkg::IDX_A_TAP8: begin
					hit_coef = 1'b1;
					sel = feq_pkg::SLOT_A_TAP8;
				end
				feq_pkg::IDX_A_TAP9: begin
					hit_coef = 1'b1;
					sel = feq_pkg::SLOT_A_TAP9;
				end
				feq_pkg::IDX_B_TAP1: begin
					hit_coef = 1'b1;
					sel = feq_pkg::SLOT_B_TAP1;
				end
				feq_pkg::IDX_B_TAP2: begin
					hit_coef = 1'b1;
					sel = feq_pkg::SLOT_B_TAP2;
				end
				feq_pkg::IDX_B_TAP3: begin
					hit_coef = 1'b1;
					sel = feq_pkg::SLOT_B_TAP3;
				end
				feq_pkg::IDX_MODE: begin
					hit_mode = 1'b1;
				end
				default: begin
					hit_coef = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// write path with byte lanes
	// ------------------------------------------------------------
	logic [feq_pkg::WORD_W-1:0] old_word;

	always_comb begin
		old_word = coef.word[sel];
		coef.we = access && pwrite && hit_coef;
		coef.wsel = sel;
		coef.wdata[7:0] = pstrb[0] ? pwdata[7:0] : old_word[7:0];
		coef.wdata[15:8] = pstrb[1] ? pwdata[15:8] : old_word[15:8];
		coef.rd_en = setup && !pwrite && hit_coef;
		coef.rsel = sel;
	end

	// ------------------------------------------------------------
	// mode register
	// ------------------------------------------------------------
	logic mode_q;
	logic mode_d;

	always_comb begin
		mode_d = mode_q;
		if (access && pwrite && hit_mode && pstrb[0]) begin
			mode_d = pwdata[feq_pkg::MODE_SINGLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= feq_pkg::MODE_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	assign single_channel = mode_q;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic rd_coef_q;
	logic rd_coef_d;
	logic rd_mode_q;
	logic rd_mode_d;

	always_comb begin
		rd_coef_d = rd_coef_q;
		rd_mode_d = rd_mode_q;
		if (setup) begin
			rd_coef_d = !pwrite && hit_coef;
			rd_mode_d = !pwrite && hit_mode;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_coef_q <= 1'b0;
			rd_mode_q <= 1'b0;
		end else begin
			rd_coef_q <= rd_coef_d;
			rd_mode_q <= rd_mode_d;
		end
	end

	always_comb begin
		prdata = '0;
		if (rd_coef_q) begin
			prdata[feq_pkg::WORD_W-1:0] = coef.rdata & feq_pkg::READ_MASK;
		end else if (rd_mode_q) begin
			prdata[feq_pkg::MODE_SINGLE_BIT] = mode_q;
		end
	end

	assign pready = access;
	assign pslverr = access && !(hit_coef || hit_mode);

	// ------------------------------------------------------------
	// tap weights toward the filter
	// ------------------------------------------------------------
	logic [feq_pkg::NUM_COEF-1:0][feq_pkg::COEF_W-1:0] wt_q;
	logic [feq_pkg::NUM_COEF-1:0][feq_pkg::COEF_W-1:0] wt_d;

	for (genvar g = 0; g < feq_pkg::NUM_COEF; g++) begin : g_wt
		// only the 12-bit outer taps live here; the 18-bit center is elsewhere
		always_comb begin
			wt_d[g] = coef.word[g][feq_pkg::COEF_W-1:0];
			if (g >= int'(feq_pkg::SLOT_B_TAP1) && mode_q) begin
				wt_d[g] = '0;
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				wt_q[g] <= '0;
			end else begin
				wt_q[g] <= wt_d[g];
			end
		end
	end

	assign chan_a_tap8_weight = wt_q[feq_pkg::SLOT_A_TAP8];
	assign chan_a_tap9_weight = wt_q[feq_pkg::SLOT_A_TAP9];
	assign chan_b_tap1_weight = wt_q[feq_pkg::SLOT_B_TAP1];
	assign chan_b_tap2_weight = wt_q[feq_pkg::SLOT_B_TAP2];
	assign chan_b_tap3_weight = wt_q[feq_pkg::SLOT_B_TAP3];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_reset_clears: assert property (@(posedge pclk)
		!presetn |-> (coef.word == '0 && wt_q == '0))
		else $error("coefficients not zero under reset");

	a_write_stores: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_coef && pstrb[1:0] == 2'h3)
		|=> coef.word[$past(sel)] == $past(pwdata[15:0]))
		else $error("coefficient write not stored");

	a_tap8_follows: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && idx == feq_pkg::IDX_A_TAP8 && paddr[1:0] == 2'h0
		&& paddr[15:14] == 2'h0 && pstrb[1:0] == 2'h3)
		|-> ##2 chan_a_tap8_weight == $past(pwdata[11:0], 2))
		else $error("tap eight weight does not follow its register");

	a_tap9_follows: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_coef && sel == feq_pkg::SLOT_A_TAP9 && pstrb[1:0] == 2'h3)
		|-> ##2 chan_a_tap9_weight == $past(pwdata[11:0], 2))
		else $error("tap nine weight does not follow its register");

	a_b_tap1_dual: assert property (@(posedge pclk) disable iff (!presetn)
		(!mode_q && !mode_d && coef.we && coef.wsel == feq_pkg::SLOT_B_TAP1)
		|-> ##2 chan_b_tap1_weight == $past(coef.wdata[11:0], 2))
		else $error("channel b tap one weight wrong in dual mode");

	a_b_tap2_dual: assert property (@(posedge pclk) disable iff (!presetn)
		!single_channel ##1 !single_channel |-> chan_b_tap2_weight
		== $past(coef.word[feq_pkg::SLOT_B_TAP2][11:0]))
		else $error("channel b tap two weight wrong in dual mode");

	a_b_tap3_dual: assert property (@(posedge pclk) disable iff (!presetn)
		(!mode_q && !mode_d && coef.we && coef.wsel == feq_pkg::SLOT_B_TAP3)
		|-> ##2 chan_b_tap3_weight == $past(coef.wdata[11:0], 2))
		else $error("channel b tap three weight wrong in dual mode");

	a_read_sign: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && hit_coef)
		|-> prdata[11] == 1'b0 && prdata[31:16] == '0
		&& prdata[10:0] == coef.word[sel][10:0] && prdata[15:12] == coef.word[sel][15:12])
		else $error("coefficient readback wrong");

	a_single_mutes: assert property (@(posedge pclk) disable iff (!presetn)
		single_channel |=> (chan_b_tap1_weight == '0 && chan_b_tap2_weight == '0
		&& chan_b_tap3_weight == '0))
		else $error("channel b weights active in single mode");

	a_single_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_mode) |=> coef.word == $past(coef.word))
		else $error("mode change disturbed stored coefficients");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !hit_coef && !hit_mode) |-> pslverr && pready ##1 coef.word == $past(coef.word))
		else $error("unmapped access not refused");

	a_reset_outputs: assert property (@(posedge pclk)
		!presetn |-> (prdata == '0 && single_channel == 1'b0
		&& chan_a_tap8_weight == '0 && chan_b_tap3_weight == '0))
		else $error("outputs not cleared under reset");

	a_lane_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_coef && !pstrb[1])
		|=> coef.word[$past(sel)][15:8] == $past(coef.word[sel][15:8]))
		else $error("unstrobed upper byte changed");

	a_tap8_single: assert property (@(posedge pclk) disable iff (!presetn)
		single_channel |=> chan_a_tap8_weight
		== $past(coef.word[feq_pkg::SLOT_A_TAP8][11:0]))
		else $error("tap eight weight lost in single mode");

	a_tap9_single: assert property (@(posedge pclk) disable iff (!presetn)
		single_channel |=> chan_a_tap9_weight
		== $past(coef.word[feq_pkg::SLOT_A_TAP9][11:0]))
		else $error("tap nine weight lost in single mode");

	a_b_restore: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(single_channel) |=> chan_b_tap1_weight
		== $past(coef.word[feq_pkg::SLOT_B_TAP1][11:0]) && chan_b_tap2_weight
		== $past(coef.word[feq_pkg::SLOT_B_TAP2][11:0]))
		else $error("channel b weights not restored in dual mode");

	a_b_kept_single: assert property (@(posedge pclk) disable iff (!presetn)
		(single_channel && !coef.we) |=> coef.word[feq_pkg::SLOT_B_TAP1]
		== $past(coef.word[feq_pkg::SLOT_B_TAP1]))
		else $error("channel b word lost in single mode");

	a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && hit_mode && pstrb[0])
		|=> single_channel == $past(pwdata[feq_pkg::MODE_SINGLE_BIT]))
		else $error("mode write not taken");

	a_read_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && hit_mode) |-> prdata == {31'h0, single_channel})
		else $error("mode readback wrong");

	a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && !hit_coef && !hit_mode) |-> prdata == '0)
		else $error("unmapped read not zero");

endmodule // feq_coef_bank

// ---- test_fir_equalizer_coef_bank.sv ----
// self-checking testbench for the equalizer coefficient bank
`timescale 1ns/1ps
module test_fir_equalizer_coef_bank;
	// ------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic single_channel;
	logic [4:0][11:0] w_seen;
	logic rdy_s, err_s, rerr;
	logic [31:0] rd_s, rdat;
	logic [15:0] mem [6];
	logic [15:0] seed = 16'd9110;
	int mismatches = 0;
	int cmp_count = 0;

	feq_coef_bank DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.single_channel(single_channel),
		.chan_a_tap8_weight(w_seen[0]), .chan_a_tap9_weight(w_seen[1]),
		.chan_b_tap1_weight(w_seen[2]), .chan_b_tap2_weight(w_seen[3]),
		.chan_b_tap3_weight(w_seen[4])
	);

	always #12.5 pclk = ~pclk;

	// values at the falling edge equal those at the next rising edge
	always @(negedge pclk) begin
		rdy_s <= pready;
		err_s <= pslverr;
		rd_s <= prdata;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic logic [15:0] reg_addr(input int i);
		case (i)
			0: return {2'h0, feq_pkg::IDX_A_TAP8, 2'h0};
			1: return {2'h0, feq_pkg::IDX_A_TAP9, 2'h0};
			2: return {2'h0, feq_pkg::IDX_B_TAP1, 2'h0};
			3: return {2'h0, feq_pkg::IDX_B_TAP2, 2'h0};
			4: return {2'h0, feq_pkg::IDX_B_TAP3, 2'h0};
			default: return {2'h0, feq_pkg::IDX_MODE, 2'h0};
		endcase
	endfunction

	function automatic logic [11:0] exp_w(input int i);
		if (i >= 2 && mem[5][0])
			return 12'h000;
		return mem[i][11:0];
	endfunction

	function automatic logic [31:0] exp_rd(input int i);
		if (i == 5)
			return {31'h0, mem[5][0]};
		return {16'h0, mem[i] & feq_pkg::READ_MASK};
	endfunction

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rdy_s !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		rdat = rd_s;
		rerr = err_s;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, reg_addr(i), d, s);
		chk("write error", rerr, 1'b0);
		if (s[0])
			mem[i][7:0] = (i == 5) ? {7'h0, d[0]} : d[7:0];
		if (s[1] && i != 5)
			mem[i][15:8] = d[15:8];
	endtask

	task automatic rd(input int i);
		apb(1'b0, reg_addr(i), 32'h0, 4'h0);
		chk("read data", rdat, exp_rd(i));
		chk("read error", rerr, 1'b0);
	endtask

	task automatic chk_out();
		@(posedge pclk);
		@(negedge pclk);
		chk("mode", single_channel, mem[5][0]);
		for (int i = 0; i < 5; i++)
			chk("weight", w_seen[i], exp_w(i));
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		for (int i = 0; i < 6; i++)
			mem[i] = 16'h0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk_out();
		for (int i = 0; i < 6; i++)
			rd(i);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] bad [4];
		bad = '{16'h109e, 16'h10a0, 16'h509c, 16'h0000};
		do_reset();
		// corner values around the sign bit and reserved bits
		wr(0, 32'hffff_ffff, 4'hf);
		wr(1, 32'h0000_0800, 4'h3);
		wr(2, 32'h0000_07ff, 4'h3);
		wr(3, 32'h0000_f800, 4'h3);
		wr(4, 32'h0000_00a5, 4'h1);
		wr(4, 32'h0000_5a5a, 4'h2);
		chk_out();
		for (int i = 0; i < 5; i++)
			rd(i);
		// random traffic with random lanes
		for (int k = 0; k < 40; k++) begin
			seed = lfsr(seed);
			wr(seed[2:0] % 5, {seed, lfsr(seed)}, seed[7:4]);
			seed = lfsr(seed);
			rd(seed[2:0] % 5);
			chk_out();
		end
		// unmapped and misaligned places refuse and keep contents
		foreach (bad[j]) begin
			apb(1'b1, bad[j], 32'h0000_ffff, 4'hf);
			chk("unmapped write error", rerr, 1'b1);
			apb(1'b0, bad[j], 32'h0, 4'h0);
			chk("unmapped read error", rerr, 1'b1);
			chk("unmapped read data", rdat, 32'h0);
		end
		for (int i = 0; i < 5; i++)
			rd(i);
		// single-channel mode mutes channel b but keeps its words
		wr(5, 32'h0000_0001, 4'hf);
		chk_out();
		for (int i = 0; i < 6; i++)
			rd(i);
		wr(2, 32'h0000_0123, 4'h3);
		chk_out();
		wr(5, 32'h0000_0000, 4'hf);
		chk_out();
		// reset in mid-run clears everything
		wr(1, 32'h0000_0fff, 4'h3);
		do_reset();
		test_done();
	end

	initial begin
		#(25ns * 20000);
		mismatches++;
		test_done();
	end
endmodule // test_fir_equalizer_coef_bank
